/* File: design/adc_cond_pkg.sv */
// Constants for the ADC encoder and phase current conditioning block
package adc_cond_pkg;

	localparam int ADDR_W = 7;
	localparam int DATA_W = 32;
	localparam int SAMPLE_W = 16;
	localparam int N_CHAN = 3;

	// Register indices on the register port
	localparam logic [6:0] OFS_INPUT_STAGE = 7'h0C;
	localparam logic [6:0] OFS_ENC_CAL0 = 7'h0D;
	localparam logic [6:0] OFS_ENC_CAL1 = 7'h0E;
	localparam logic [6:0] OFS_ENC_CAL2 = 7'h0F;
	localparam logic [6:0] OFS_ENC_ROUTING = 7'h11;
	localparam logic [6:0] OFS_CUR_WY_UX = 7'h12;
	localparam logic [6:0] OFS_CUR_V = 7'h13;
	localparam logic [6:0] OFS_ENC_WY_UX = 7'h15;
	localparam logic [6:0] OFS_ENC_VN = 7'h16;

	// Field positions
	localparam int CAL_OFFSET_LSB = 0;
	localparam int CAL_SCALE_LSB = 16;
	localparam int SEL_W = 8;
	localparam int STAGE_FIELD_W = 4;
	localparam int STAGE_ENC_VN_LSB = 24;
	localparam int STAGE_ENC_WY_LSB = 28;
	localparam int MON_LOW_LSB = 0;
	localparam int MON_HIGH_LSB = 16;

	// Source selector codes
	localparam logic [7:0] SEL_UX = 8'h00;
	localparam logic [7:0] SEL_VN = 8'h01;
	localparam logic [7:0] SEL_WY = 8'h02;

	// Reset values
	localparam logic [31:0] RST_INPUT_STAGE = 32'h0000_0000;
	localparam logic [31:0] RST_ENC_CAL = 32'h0100_0000;
	localparam logic [31:0] RST_ENC_ROUTING = 32'h0002_0100;

	// Product shift applied before the 16-bit cut
	localparam int SCALE_SHIFT = 8;

endpackage

/* File: design/sample_conditioner.sv */
// One channel of offset subtraction, signed scaling and 16-bit truncation
`timescale 1ns/1ps
module sample_conditioner #(
	parameter int W     = 16,
	parameter int SHIFT = 8
) (
	input  wire logic                sys_clk,
	input  wire logic                rst_n,
	input  wire logic                sample_valid,
	input  wire logic [W-1:0]        raw,
	input  wire logic [W-1:0]        offset,
	input  wire logic signed [W-1:0] scale,
	output logic signed [W-1:0]      value_q,
	output logic                     valid_q
);
	logic signed [W:0]     diff;
	logic signed [2*W:0]   prod;
	logic signed [2*W:0]   shifted;
	logic signed [W-1:0]   value_d;

	// Arithmetic and hold; value only moves on a fresh sample
	// subtract scale truncate
	always_comb
	begin
		diff = $signed({1'b0, raw}) - $signed({1'b0, offset});
		// Widen both factors first so the full product survives
		prod = (2*W+1)'(diff) * (2*W+1)'(scale);
		shifted = prod >>> SHIFT;
		value_d = sample_valid ? shifted[W-1:0] : value_q;
	end

	// Registered so the loop and the monitor see the same flop
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			value_q <= '0;
			valid_q <= 1'b0;
		end
		else
		begin
			value_q <= value_d;
			valid_q <= sample_valid;
		end
	end

	value_calc_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		sample_valid |=> value_q == $past(shifted[W-1:0]))
		else $error("conditioned value does not match formula");

	value_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!sample_valid |=> $stable(value_q) && !valid_q)
		else $error("conditioned value moved without a sample");
endmodule

/* File: design/adc_conditioning.sv */
// Register file, encoder routing and six conditioning channels
`timescale 1ns/1ps
module adc_conditioning
	import adc_cond_pkg::*;
#(
	parameter int SHIFT = adc_cond_pkg::SCALE_SHIFT
) (
	input  wire logic                                sys_clk,
	input  wire logic                                rst_n,
	input  wire logic [adc_cond_pkg::ADDR_W-1:0]     reg_addr,
	input  wire logic                                reg_wr_en,
	input  wire logic [adc_cond_pkg::DATA_W-1:0]     reg_wdata,
	input  wire logic                                reg_rd_en,
	output logic [adc_cond_pkg::DATA_W-1:0]          reg_rd_data,
	output logic                                     reg_rd_valid,
	input  wire logic [adc_cond_pkg::SAMPLE_W-1:0]   raw_enc_input_ux,
	input  wire logic [adc_cond_pkg::SAMPLE_W-1:0]   raw_enc_input_vn,
	input  wire logic [adc_cond_pkg::SAMPLE_W-1:0]   raw_enc_input_wy,
	input  wire logic                                enc_sample_valid,
	input  wire logic [adc_cond_pkg::SAMPLE_W-1:0]   raw_current_ux,
	input  wire logic [adc_cond_pkg::SAMPLE_W-1:0]   raw_current_v,
	input  wire logic [adc_cond_pkg::SAMPLE_W-1:0]   raw_current_wy,
	input  wire logic                                current_sample_valid,
	input  wire logic [adc_cond_pkg::SAMPLE_W-1:0]   current_offset_ux,
	input  wire logic [adc_cond_pkg::SAMPLE_W-1:0]   current_offset_v,
	input  wire logic [adc_cond_pkg::SAMPLE_W-1:0]   current_offset_wy,
	input  wire logic [adc_cond_pkg::SAMPLE_W-1:0]   current_scale_ux,
	input  wire logic [adc_cond_pkg::SAMPLE_W-1:0]   current_scale_v,
	input  wire logic [adc_cond_pkg::SAMPLE_W-1:0]   current_scale_wy,
	output logic signed [adc_cond_pkg::SAMPLE_W-1:0] enc_ux_conditioned,
	output logic signed [adc_cond_pkg::SAMPLE_W-1:0] enc_vn_conditioned,
	output logic signed [adc_cond_pkg::SAMPLE_W-1:0] enc_wy_conditioned,
	output logic                                     enc_conditioned_valid,
	output logic signed [adc_cond_pkg::SAMPLE_W-1:0] current_ux_conditioned,
	output logic signed [adc_cond_pkg::SAMPLE_W-1:0] current_v_conditioned,
	output logic signed [adc_cond_pkg::SAMPLE_W-1:0] current_wy_conditioned,
	output logic                                     current_conditioned_valid,
	output logic [adc_cond_pkg::DATA_W-1:0]          input_stage_cfg,
	output logic [adc_cond_pkg::STAGE_FIELD_W-1:0]   input_stage_enc_vn,
	output logic [adc_cond_pkg::STAGE_FIELD_W-1:0]   input_stage_enc_wy
);
	import adc_cond_pkg::*;

	localparam int NC = 2 * N_CHAN;

	logic [DATA_W-1:0]   stage_q;
	logic [DATA_W-1:0]   stage_d;
	logic [DATA_W-1:0]   cal_q [0:N_CHAN-1];
	logic [DATA_W-1:0]   cal_d [0:N_CHAN-1];
	logic [DATA_W-1:0]   routing_q;
	logic [DATA_W-1:0]   routing_d;
	logic [DATA_W-1:0]   rd_data_d;
	logic                rd_valid_d;
	logic [SAMPLE_W-1:0] raw_enc [0:N_CHAN-1];
	logic [SAMPLE_W-1:0] ch_raw [0:NC-1];
	logic [SAMPLE_W-1:0] ch_offset [0:NC-1];
	logic [SAMPLE_W-1:0] ch_scale [0:NC-1];
	logic                ch_in_valid [0:NC-1];
	logic [SAMPLE_W-1:0] ch_value [0:NC-1];
	logic                ch_valid [0:NC-1];
	logic [SEL_W-1:0]    sel_code [0:N_CHAN-1];

	// Register writes; unmapped and read-only offsets ignore writes
	always_comb
	begin
		stage_d = stage_q;
		routing_d = routing_q;
		for (int i = 0; i < N_CHAN; i++)
			cal_d[i] = cal_q[i];
		if (reg_wr_en)
		begin
			unique case (reg_addr)
				OFS_INPUT_STAGE: stage_d = reg_wdata;
				OFS_ENC_CAL0:    cal_d[0] = reg_wdata;
				OFS_ENC_CAL1:    cal_d[1] = reg_wdata;
				OFS_ENC_CAL2:    cal_d[2] = reg_wdata;
				OFS_ENC_ROUTING: routing_d = reg_wdata;
				default:         ;
			endcase
		end
	end

	// Configuration storage
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			stage_q <= RST_INPUT_STAGE;
			routing_q <= RST_ENC_ROUTING;
			for (int i = 0; i < N_CHAN; i++)
				cal_q[i] <= RST_ENC_CAL;
		end
		else
		begin
			stage_q <= stage_d;
			routing_q <= routing_d;
			for (int i = 0; i < N_CHAN; i++)
				cal_q[i] <= cal_d[i];
		end
	end

	// Source routing fixes swapped sensor wiring
	// selector decode
	always_comb
	begin
		raw_enc[0] = raw_enc_input_ux;
		raw_enc[1] = raw_enc_input_vn;
		raw_enc[2] = raw_enc_input_wy;
		for (int k = 0; k < N_CHAN; k++)
		begin
			sel_code[k] = routing_q[k*SEL_W +: SEL_W];
			if (sel_code[k] == SEL_VN)
				ch_raw[k] = raw_enc[1];
			else if (sel_code[k] == SEL_WY)
				ch_raw[k] = raw_enc[2];
			else
				ch_raw[k] = raw_enc[0];
			ch_offset[k] = cal_q[k][CAL_OFFSET_LSB +: SAMPLE_W];
			ch_scale[k] = cal_q[k][CAL_SCALE_LSB +: SAMPLE_W];
			ch_in_valid[k] = enc_sample_valid;
		end
		ch_raw[3] = raw_current_ux;
		ch_raw[4] = raw_current_v;
		ch_raw[5] = raw_current_wy;
		ch_offset[3] = current_offset_ux;
		ch_offset[4] = current_offset_v;
		ch_offset[5] = current_offset_wy;
		ch_scale[3] = current_scale_ux;
		ch_scale[4] = current_scale_v;
		ch_scale[5] = current_scale_wy;
		for (int k = N_CHAN; k < NC; k++)
			ch_in_valid[k] = current_sample_valid;
	end

	// Channels 0..2 encoder, 3..5 phase currents
	for (genvar g = 0; g < NC; g++)
	begin : g_chan
		sample_conditioner #(
			.W     (SAMPLE_W),
			.SHIFT (SHIFT)
		) u_cond (
			.sys_clk      (sys_clk),
			.rst_n        (rst_n),
			.sample_valid (ch_in_valid[g]),
			.raw          (ch_raw[g]),
			.offset       (ch_offset[g]),
			.scale        (ch_scale[g]),
			.value_q      (ch_value[g]),
			.valid_q      (ch_valid[g])
		);
	end

	// Outputs are the channel flops themselves, so monitor equals loop input
	// shared value path
	assign enc_ux_conditioned = ch_value[0];
	assign enc_vn_conditioned = ch_value[1];
	assign enc_wy_conditioned = ch_value[2];
	assign enc_conditioned_valid = ch_valid[0];
	assign current_ux_conditioned = ch_value[3];
	assign current_v_conditioned = ch_value[4];
	assign current_wy_conditioned = ch_value[5];
	assign current_conditioned_valid = ch_valid[3];
	assign input_stage_cfg = stage_q;
	assign input_stage_enc_vn = stage_q[STAGE_ENC_VN_LSB +: STAGE_FIELD_W];
	assign input_stage_enc_wy = stage_q[STAGE_ENC_WY_LSB +: STAGE_FIELD_W];

	// Read mux; unmapped offsets answer zero
	always_comb
	begin
		rd_data_d = reg_rd_data;
		rd_valid_d = reg_rd_en;
		if (reg_rd_en)
		begin
			rd_data_d = '0;
			unique case (reg_addr)
				OFS_INPUT_STAGE: rd_data_d = stage_q;
				OFS_ENC_CAL0:    rd_data_d = cal_q[0];
				OFS_ENC_CAL1:    rd_data_d = cal_q[1];
				OFS_ENC_CAL2:    rd_data_d = cal_q[2];
				OFS_ENC_ROUTING: rd_data_d = routing_q;
				OFS_CUR_WY_UX:
				begin
					rd_data_d[MON_LOW_LSB +: SAMPLE_W] = ch_value[3];
					rd_data_d[MON_HIGH_LSB +: SAMPLE_W] = ch_value[5];
				end
				OFS_CUR_V:
					rd_data_d[MON_LOW_LSB +: SAMPLE_W] = ch_value[4];
				OFS_ENC_WY_UX:
				begin
					rd_data_d[MON_LOW_LSB +: SAMPLE_W] = ch_value[0];
					rd_data_d[MON_HIGH_LSB +: SAMPLE_W] = ch_value[2];
				end
				OFS_ENC_VN:
					rd_data_d[MON_LOW_LSB +: SAMPLE_W] = ch_value[1];
				default:         ;
			endcase
		end
	end

	// Read data held until the next read so software can sample late
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			reg_rd_data <= '0;
			reg_rd_valid <= 1'b0;
		end
		else
		begin
			reg_rd_data <= rd_data_d;
			reg_rd_valid <= rd_valid_d;
		end
	end

	cal_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_wr_en && reg_addr == OFS_ENC_CAL1
		|=> cal_q[1] == $past(reg_wdata))
		else $error("calibration write lost");

	cal_readback_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_rd_en && !reg_wr_en && reg_addr == OFS_ENC_CAL2
		|=> reg_rd_valid && reg_rd_data == cal_q[2])
		else $error("calibration readback wrong");

	enc_scale_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		ch_scale[0] == cal_q[0][31:16] && ch_offset[0] == cal_q[0][15:0])
		else $error("calibration fields misplaced");

	route_vn_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		enc_sample_valid && routing_q[23:16] == SEL_VN
		|-> ch_raw[2] == raw_enc_input_vn)
		else $error("selector code one not routing VN");

	route_bad_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		routing_q[15:8] > SEL_WY |-> ch_raw[1] == raw_enc_input_ux)
		else $error("undefined selector not routing UX");

	cur_monitor_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_rd_en && reg_addr == OFS_CUR_WY_UX
		|=> reg_rd_data == {$past(current_wy_conditioned),
			$past(current_ux_conditioned)})
		else $error("current monitor differs from loop value");

	v_monitor_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_rd_en && reg_addr == OFS_CUR_V
		|=> reg_rd_data[31:16] == 16'h0000
		&& reg_rd_data[15:0] == $past(current_v_conditioned))
		else $error("V current monitor wrong");

	enc_monitor_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_rd_en && reg_addr == OFS_ENC_WY_UX
		|=> reg_rd_data == {$past(enc_wy_conditioned),
			$past(enc_ux_conditioned)})
		else $error("encoder monitor wrong");

	vn_monitor_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_rd_en && reg_addr == OFS_ENC_VN
		|=> reg_rd_data == {16'h0000, $past(enc_vn_conditioned)})
		else $error("VN monitor wrong");

	ro_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_wr_en && reg_addr != OFS_ENC_ROUTING |=> $stable(routing_q))
		else $error("routing changed by foreign write");

	stage_field_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_wr_en && reg_addr == OFS_INPUT_STAGE
		|=> input_stage_enc_wy == $past(reg_wdata[31:28]))
		else $error("input stage field not applied");

	unmapped_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reg_rd_en && reg_addr == 7'h14 |=> reg_rd_data == 32'h0000_0000)
		else $error("unmapped read not zero");
endmodule

/* File: testbench/loop_sink.sv */
// Capture sink standing in for the current control loop
`timescale 1ns/1ps
module loop_sink
	import adc_cond_pkg::*;
(
	input  wire logic                              sys_clk,
	input  wire logic                              rst_n,
	input  wire logic                              in_valid,
	input  wire logic [adc_cond_pkg::SAMPLE_W-1:0] in_ux,
	input  wire logic [adc_cond_pkg::SAMPLE_W-1:0] in_v,
	input  wire logic [adc_cond_pkg::SAMPLE_W-1:0] in_wy,
	output logic [adc_cond_pkg::SAMPLE_W-1:0]      got_ux,
	output logic [adc_cond_pkg::SAMPLE_W-1:0]      got_v,
	output logic [adc_cond_pkg::SAMPLE_W-1:0]      got_wy
);
	// Takes values only on the valid pulse, as the real loop would
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			got_ux <= 16'h0000;
			got_v  <= 16'h0000;
			got_wy <= 16'h0000;
		end
		else if (in_valid)
		begin
			got_ux <= in_ux;
			got_v  <= in_v;
			got_wy <= in_wy;
		end
	end
endmodule

/* File: testbench/testbench.sv */
// Self-checking bench for the ADC conditioning block
`timescale 1ns/1ps
module testbench;
	import adc_cond_pkg::*;
	logic        sys_clk, rst_n, reg_wr_en, reg_rd_en, enc_vld, cur_vld;
	logic [6:0]  reg_addr;
	logic [31:0] reg_wdata, cal_m [3], sel_m;
	logic [15:0] enc_raw [3], cur_raw [3], cur_off [3], cur_scl [3];
	wire  [31:0] reg_rd_data, stage_cfg;
	wire  [15:0] enc_out [3], cur_out [3], got [3];
	wire  [3:0]  stage_vn, stage_wy;
	wire         reg_rd_valid, enc_ovld, cur_ovld;
	int          err_total, n_compared;

	adc_conditioning adc_conditioning_inst (.sys_clk(sys_clk),
		.rst_n(rst_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
		.reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
		.reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
		.raw_enc_input_ux(enc_raw[0]), .raw_enc_input_vn(enc_raw[1]),
		.raw_enc_input_wy(enc_raw[2]), .enc_sample_valid(enc_vld),
		.raw_current_ux(cur_raw[0]), .raw_current_v(cur_raw[1]),
		.raw_current_wy(cur_raw[2]), .current_sample_valid(cur_vld),
		.current_offset_ux(cur_off[0]), .current_offset_v(cur_off[1]),
		.current_offset_wy(cur_off[2]), .current_scale_ux(cur_scl[0]),
		.current_scale_v(cur_scl[1]), .current_scale_wy(cur_scl[2]),
		.enc_ux_conditioned(enc_out[0]), .enc_vn_conditioned(enc_out[1]),
		.enc_wy_conditioned(enc_out[2]), .enc_conditioned_valid(enc_ovld),
		.current_ux_conditioned(cur_out[0]),
		.current_v_conditioned(cur_out[1]),
		.current_wy_conditioned(cur_out[2]),
		.current_conditioned_valid(cur_ovld), .input_stage_cfg(stage_cfg),
		.input_stage_enc_vn(stage_vn), .input_stage_enc_wy(stage_wy));

	loop_sink loop_sink_inst (.sys_clk(sys_clk), .rst_n(rst_n),
		.in_valid(cur_ovld), .in_ux(cur_out[0]), .in_v(cur_out[1]),
		.in_wy(cur_out[2]), .got_ux(got[0]), .got_v(got[1]),
		.got_wy(got[2]));

	// 25 MHz clock
	initial
	begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] seen);
		n_compared++;
		if (seen !== exp)
		begin
			$display("ERROR %s expected %h seen %h", what, exp, seen);
			err_total++;
		end
	endtask

	// Reference: wrap to 16 bits after the shift, as chosen for the block
	function automatic logic [15:0] cond(input logic [15:0] raw, off,
		input logic signed [15:0] scl);
		logic signed [40:0] p;
		p = ($signed({1'b0, raw}) - $signed({1'b0, off})) * scl;
		return p[SCALE_SHIFT+15:SCALE_SHIFT];
	endfunction

	task automatic reg_wr(input logic [6:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr_en <= 1'b1;
		@(posedge sys_clk);
		reg_wr_en <= 1'b0;
	endtask

	// Read and compare under a mask; valid is looked at in its one cycle
	task automatic reg_rd(input logic [6:0] a, input logic [31:0] exp,
		input logic [31:0] m);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_rd_en <= 1'b1;
		@(posedge sys_clk);
		reg_rd_en <= 1'b0;
		#1;
		check("rd_valid", 32'h1, {31'h0, reg_rd_valid});
		check("rd_data", exp & m, reg_rd_data & m);
	endtask

	function automatic logic [15:0] pick(input logic [7:0] s);
		return s == SEL_VN ? enc_raw[1] : (s == SEL_WY ? enc_raw[2] :
			enc_raw[0]);
	endfunction

	task automatic enc_run(input logic [15:0] a, b, c);
		logic [15:0] e [3];
		@(posedge sys_clk);
		enc_raw <= '{a, b, c};
		enc_vld <= 1'b1;
		@(posedge sys_clk);
		enc_vld <= 1'b0;
		#1;
		check("enc_valid", 32'h1, {31'h0, enc_ovld});
		for (int k = 0; k < 3; k++)
		begin
			e[k] = cond(pick(sel_m[8*k+:8]), cal_m[k][15:0], cal_m[k][31:16]);
			check("enc_out", {16'h0, e[k]}, {16'h0, enc_out[k]});
		end
		reg_rd(OFS_ENC_WY_UX, {e[2], e[0]}, 32'hFFFF_FFFF);
		reg_rd(OFS_ENC_VN, {16'h0, e[1]}, 32'h0000_FFFF);
	endtask

	task automatic cur_run(input logic [15:0] a, b, c);
		logic [15:0] e [3];
		@(posedge sys_clk);
		cur_raw <= '{a, b, c};
		cur_vld <= 1'b1;
		@(posedge sys_clk);
		cur_vld <= 1'b0;
		#1;
		check("cur_valid", 32'h1, {31'h0, cur_ovld});
		for (int k = 0; k < 3; k++)
		begin
			e[k] = cond(cur_raw[k], cur_off[k], cur_scl[k]);
			check("cur_out", {16'h0, e[k]}, {16'h0, cur_out[k]});
		end
		@(posedge sys_clk);
		#1;
		for (int k = 0; k < 3; k++)
			check("loop_in", {16'h0, e[k]}, {16'h0, got[k]});
		reg_rd(OFS_CUR_WY_UX, {e[2], e[0]}, 32'hFFFF_FFFF);
		reg_rd(OFS_CUR_V, {16'h0, e[1]}, 32'h0000_FFFF);
	endtask

	task automatic t_reset;
		for (int k = 0; k < 3; k++)
			reg_rd(OFS_ENC_CAL0 + 7'(k), RST_ENC_CAL, 32'hFFFF_FFFF);
		reg_rd(OFS_ENC_ROUTING, RST_ENC_ROUTING, 32'hFFFF_FFFF);
		reg_rd(OFS_INPUT_STAGE, RST_INPUT_STAGE, 32'hFFFF_FFFF);
		reg_rd(7'h10, 32'h0, 32'hFFFF_FFFF);
		reg_rd(7'h14, 32'h0, 32'hFFFF_FFFF);
		$display("reset test done");
	endtask

	// Distinct words per channel; read-only monitor must ignore writes
	task automatic t_cal;
		cal_m = '{32'h0100_8000, 32'hFF00_1000, 32'h7FFF_0000};
		for (int k = 0; k < 3; k++)
			reg_wr(OFS_ENC_CAL0 + 7'(k), cal_m[k]);
		for (int k = 0; k < 3; k++)
			reg_rd(OFS_ENC_CAL0 + 7'(k), cal_m[k], 32'hFFFF_FFFF);
		reg_wr(OFS_CUR_WY_UX, 32'h1234_5678);
		reg_rd(OFS_CUR_WY_UX, 32'h0, 32'hFFFF_FFFF);
		$display("calibration test done");
	endtask

	task automatic t_enc;
		enc_run(16'h9000, 16'h0F00, 16'h0300);
		enc_run(16'h7FFF, 16'hFFFF, 16'hFFFF);
		@(posedge sys_clk);
		#1;
		check("enc_valid_low", 32'h0, {31'h0, enc_ovld});
		$display("encoder test done");
	endtask

	// Swaps and two undocumented codes (0x03, 0xFF) that must fall back to UX
	task automatic t_route;
		logic [31:0] tbl [3];
		tbl = '{32'h0000_0102, 32'h0001_0002, 32'h00FF_0302};
		for (int i = 0; i < 3; i++)
		begin
			reg_wr(OFS_ENC_ROUTING, tbl[i]);
			sel_m = tbl[i];
			reg_rd(OFS_ENC_ROUTING, tbl[i], 32'h00FF_FFFF);
			enc_run(16'h1111 * 16'(i + 1), 16'hA0A0, 16'h0404);
		end
		$display("routing test done");
	endtask

	task automatic t_cur;
		@(posedge sys_clk);
		cur_off <= '{16'h0800, 16'h0000, 16'hF000};
		cur_scl <= '{16'h0100, 16'h8000, 16'h0180};
		cur_run(16'h0900, 16'h0002, 16'h1000);
		cur_run(16'h0000, 16'hFFFF, 16'hFFFF);
		$display("current test done");
	endtask

	// Input-stage codes 0 to 7 in both encoder fields
	task automatic t_stage;
		logic [31:0] w;
		for (int c = 0; c < 8; c++)
		begin
			w = {4'(c), 4'(7 - c), 24'h5A5A5A};
			reg_wr(OFS_INPUT_STAGE, w);
			reg_rd(OFS_INPUT_STAGE, w, 32'hFFFF_FFFF);
			check("stage_cfg", w, stage_cfg);
			check("stage_vn", 32'(7 - c), {28'h0, stage_vn});
			check("stage_wy", 32'(c), {28'h0, stage_wy});
		end
		$display("input stage test done");
	endtask

	task automatic conclude;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Hang guard well above the run length
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		$display("ERROR watchdog expected end seen timeout");
		err_total++;
		conclude();
	end

	initial
	begin
		{rst_n, reg_wr_en, reg_rd_en, enc_vld, cur_vld} = 5'h00;
		reg_addr = 7'h00;
		reg_wdata = 32'h0;
		enc_raw = '{16'h0, 16'h0, 16'h0};
		cur_raw = '{16'h0, 16'h0, 16'h0};
		cur_off = '{16'h0, 16'h0, 16'h0};
		cur_scl = '{16'h0100, 16'h0100, 16'h0100};
		sel_m = RST_ENC_ROUTING;
		err_total = 0;
		n_compared = 0;
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_reset();
		t_cal();
		t_enc();
		t_route();
		t_cur();
		t_stage();
		conclude();
	end
endmodule
